// [hw/sbd_bus_decode.sv]
// Bus-side decode and glue of the support board.
// Assumes bus strobes are synchronous to ref_clk_i; switch, jumper and
// terminal inputs are asynchronous and pass two flip-flops first.
`timescale 1ns/10ps
`default_nettype none
module sbd_bus_decode (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic [19:0] addr_i,
  input  wire logic        mem_cycle_i,
  input  wire logic        io_rd_i,
  input  wire logic        io_wr_i,
  input  wire logic        high_speed_i,
  input  wire logic [7:0]  port_block_a_select_switch_i,
  input  wire logic [7:0]  option_switch_bank_i,
  input  wire logic        dtr_i,
  input  wire logic        dtr_open_i,
  input  wire logic        dtr_jumper_plus_i,
  input  wire logic        out_jumper_plus_i,
  input  wire logic        ack_i,
  input  wire logic        addr_jumper_hi_i,
  input  wire logic        rom_large_i,
  input  wire logic        phantom_jumper_i,
  input  wire logic        ack_jumper_three_i,
  input  wire logic        ack_jumper_open_i,
  output logic             board_sel_o,
  output logic [3:0]       func_sel_o,
  output logic             rom_sel_o,
  output logic             phantom_o,
  output logic             wait_o,
  output logic [7:0]       rd_data_o,
  output logic             rd_data_oe_o,
  output logic             tx_enable_o,
  output logic             par_out_oe_o,
  output logic             ack_three_byte_o,
  output logic             ack_drive_bus_o
);
  localparam int NSYNC = 25;
  logic [NSYNC-1:0] s1_r, s2_r;
  logic [NSYNC-1:0] async_in;
  assign async_in = {port_block_a_select_switch_i, option_switch_bank_i, dtr_i, dtr_open_i,
                     dtr_jumper_plus_i, out_jumper_plus_i, ack_i, addr_jumper_hi_i,
                     rom_large_i, phantom_jumper_i, ack_jumper_three_i};
  logic [7:0] sw1, sw2;
  logic dtr_s, dtr_open_s, dtr_plus_s, out_plus_s, ack_s, hi_s, large_s, ph_s, three_s;
  assign {sw1, sw2, dtr_s, dtr_open_s, dtr_plus_s, out_plus_s, ack_s, hi_s, large_s, ph_s,
          three_s} = s2_r;
  logic ackop1_r, ackop2_r;

  logic       rom_off_r, rom_off_nxt;
  logic       board_sel_nxt, rom_sel_nxt, wait_nxt, rd_oe_nxt, tx_nxt, oe_nxt;
  logic       phantom_nxt, three_nxt, drive_nxt;
  logic [3:0] func_nxt;
  logic [7:0] rd_nxt;
  logic       rom_hit;
  logic       bus_cycle;

  // Offset match inside the port block; shared by disable port and switch read
  function automatic logic offset_is(input logic [19:0] a, input logic [3:0] ofs);
    offset_is = (a[3:0] == ofs);
  endfunction

  always_comb begin
    bus_cycle = mem_cycle_i | io_rd_i | io_wr_i;
    // Bit reversal: switch position one is A7
    board_sel_nxt = (io_rd_i | io_wr_i) &&
                    (addr_i[7:4] == {sw1[0], sw1[1], sw1[2], sw1[3]});
    func_nxt = addr_i[3:0];
    if (sw1[sbd_pkg::SBD_SW_EXT]) begin
      rom_hit = addr_i[19:12] == sbd_pkg::SBD_ROM_TOP20;
    end else begin
      rom_hit = addr_i[15:12] == sbd_pkg::SBD_ROM_TOP16;
    end
    if (!large_s) begin
      rom_hit = rom_hit && (addr_i[11] == hi_s);
    end // Large part covers whole 4 KB, placement ignored
    rom_sel_nxt = mem_cycle_i && rom_hit && sw1[sbd_pkg::SBD_SW_ROM_EN] &&
                  !rom_off_r;
    // Overlay only ever follows a real ROM select, never a bare address match
    phantom_nxt = rom_sel_nxt & ph_s;
    rom_off_nxt = rom_off_r;
    if (board_sel_nxt && offset_is(addr_i, sbd_pkg::SBD_OFS_ROM_OFF)) begin
      rom_off_nxt = 1'b1;
    end
    if (!sw1[sbd_pkg::SBD_SW_WAIT_ON]) begin
      wait_nxt = 1'b0;
    end else if (!sw1[sbd_pkg::SBD_SW_WAIT_SPD]) begin
      wait_nxt = bus_cycle;
    end else begin
      wait_nxt = bus_cycle & high_speed_i;
    end
    rd_oe_nxt = board_sel_nxt && io_rd_i && offset_is(addr_i, sbd_pkg::SBD_OFS_OPT_SW);
    rd_nxt = rd_oe_nxt ? sw2 : sbd_pkg::SBD_RD_IDLE;
    tx_nxt = dtr_open_s ? dtr_plus_s : dtr_s;
    // Acknowledge input open reads high after the pull-up, so data drives
    oe_nxt = out_plus_s | ack_s;
    three_nxt = three_s & !ackop2_r;
    drive_nxt = !ackop2_r;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s1_r <= '0;
      s2_r <= '0;
      ackop1_r <= 1'b1;
      ackop2_r <= 1'b1;
      rom_off_r <= 1'b0;
      board_sel_o <= 1'b0;
      func_sel_o <= 4'h0;
      rom_sel_o <= 1'b0;
      phantom_o <= 1'b0;
      wait_o <= 1'b0;
      rd_data_o <= sbd_pkg::SBD_RD_IDLE;
      rd_data_oe_o <= 1'b0;
      tx_enable_o <= 1'b0;
      par_out_oe_o <= 1'b0;
      ack_three_byte_o <= 1'b0;
      ack_drive_bus_o <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      ackop1_r <= ack_jumper_open_i;
      ackop2_r <= ackop1_r;
      rom_off_r <= rom_off_nxt;
      board_sel_o <= board_sel_nxt;
      func_sel_o <= func_nxt;
      rom_sel_o <= rom_sel_nxt;
      phantom_o <= phantom_nxt;
      wait_o <= wait_nxt;
      rd_data_o <= rd_nxt;
      rd_data_oe_o <= rd_oe_nxt;
      tx_enable_o <= tx_nxt;
      par_out_oe_o <= oe_nxt;
      ack_three_byte_o <= three_nxt;
      ack_drive_bus_o <= drive_nxt;
    end
  end

  property rom_off_sticky;
    @(posedge ref_clk_i) disable iff (reset_i)
      rom_off_r |=> rom_off_r;
  endproperty
  rom_disable_hold_a: assert property (rom_off_sticky) else $error("rom disable lost");
  rom_never_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rom_off_r |=> !rom_sel_o) else $error("rom selected after disable");
  rom_switch_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rom_sel_o |-> $past(sw1[sbd_pkg::SBD_SW_ROM_EN])) else $error("rom selected with switch open");
  phantom_follow_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    phantom_o |-> rom_sel_o) else $error("phantom without rom select");
  opt_read_data_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rd_data_oe_o |-> rd_data_o == $past(sw2)) else $error("option read wrong");
  wait_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !$past(sw1[7]) |-> !wait_o) else $error("wait with switch eight open");
  board_match_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    board_sel_o |-> $past(addr_i[7]) == $past(sw1[0])) else $error("port_block_a mismatch");
  ack_open_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !ack_drive_bus_o |-> !ack_three_byte_o) else $error("ack mode while open");

  // Steps of a disable access and of a large-part hit, shared by properties
  sequence rom_disable_access;
    board_sel_o && func_sel_o == sbd_pkg::SBD_OFS_ROM_OFF;
  endsequence
  sequence rom_large_hit;
    mem_cycle_i && large_s && sw1[sbd_pkg::SBD_SW_ROM_EN] && !sw1[sbd_pkg::SBD_SW_EXT] &&
      !rom_off_r && addr_i[15:12] == sbd_pkg::SBD_ROM_TOP16;
  endsequence
  property rom_disable_take;
    @(posedge ref_clk_i) disable iff (reset_i)
      rom_disable_access |-> rom_off_r;
  endproperty
  property rom_disable_free;
    @(posedge ref_clk_i) disable iff (reset_i)
      rom_disable_access |=> !rom_sel_o;
  endproperty
  property rom_large_whole;
    @(posedge ref_clk_i) disable iff (reset_i)
      rom_large_hit |=> rom_sel_o;
  endproperty
  rom_disable_take_a: assert property (rom_disable_take) else $error("disable port ignored");
  rom_disable_free_a: assert property (rom_disable_free) else $error("rom kept after disable");
  rom_large_range_a: assert property (rom_large_whole) else $error("large rom window missed");
  // No disable here: the check is about the reset edge itself
  rom_reset_clear_a: assert property (@(posedge ref_clk_i)
    $past(reset_i) |-> !rom_off_r) else $error("rom disable survives reset");
  board_io_only_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    board_sel_o |-> $past(io_rd_i | io_wr_i)) else $error("board select off io");
  board_low_bit_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    board_sel_o |-> $past(addr_i[4]) == $past(sw1[3])) else $error("port_block_a order wrong");
  rom_ext_window_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rom_sel_o && $past(sw1[sbd_pkg::SBD_SW_EXT]) |->
      $past(addr_i[19:12]) == sbd_pkg::SBD_ROM_TOP20) else $error("ext window wrong");
  rom_place_pick_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rom_sel_o && !$past(large_s) |-> $past(addr_i[11]) == $past(hi_s))
    else $error("rom placement wrong");
  wait_always_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(sw1[sbd_pkg::SBD_SW_WAIT_ON] && !sw1[sbd_pkg::SBD_SW_WAIT_SPD] && bus_cycle)
      |-> wait_o) else $error("wait state missing");
  wait_speed_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(sw1[sbd_pkg::SBD_SW_WAIT_ON] && sw1[sbd_pkg::SBD_SW_WAIT_SPD]) |->
      wait_o == $past(bus_cycle && high_speed_i)) else $error("speed wait wrong");
  opt_read_idle_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !rd_data_oe_o |-> rd_data_o == sbd_pkg::SBD_RD_IDLE) else $error("read data not idle");
  tx_dtr_follow_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !$past(dtr_open_s) |-> tx_enable_o == $past(dtr_s)) else $error("transmit ignores dtr");
  out_drive_on_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(out_plus_s) |-> par_out_oe_o) else $error("output not driven");
endmodule
`default_nettype wire

// [hw/sbd_pkg.sv]
// Constants for the support board bus decode block.
// Assumes a single 20 MHz bus clock and synchronous active-high reset.
// Notes on behaviour
// - Respond only when upper port bits match port_block_a
// - Switch one to four map A7 to A4
// - EPROM selectable only with ROM-enable closed
// - Extended addressing decodes 20 bits, else 16
// - Small EPROM: placement jumper picks upper or lower half of the window
// - Large EPROM spans F000 to FFFF
// - Output to disable port frees EPROM range
// - Disable port sits at block offset fourteen
// - Wait switches: none, or always one wait
// - Both closed: wait only at high speed
// - Offset fifteen reads option switch bank
// - Transmit allowed only with DTR or jumper
// - Output drive jumper: constant or follow ACK
// - Overlay jumper asserts PHANTOM on EPROM select
// - Acknowledge jumper picks three or two bytes
// - Unconnected acknowledge jumper: bus left untouched
package sbd_pkg;
  localparam logic [3:0]  SBD_OFS_ROM_OFF   = 4'hE;
  localparam logic [3:0]  SBD_OFS_OPT_SW    = 4'hF;
  localparam logic [3:0]  SBD_ROM_TOP16     = 4'hF;
  localparam logic [7:0]  SBD_ROM_TOP20     = 8'hFF;
  localparam logic [7:0]  SBD_RD_IDLE       = 8'h00;
  localparam int          SBD_WAIT_STATES   = 1;
  // Positions of the port_block_a-select switch bank, bit 0 is position one
  localparam int          SBD_SW_ROM_EN     = 4;
  localparam int          SBD_SW_EXT        = 5;
  localparam int          SBD_SW_WAIT_SPD   = 6;
  localparam int          SBD_SW_WAIT_ON    = 7;
endpackage

// [test/sbd_host_model.sv]
// Host bus master model: one bus cycle per call, one idle cycle between.
// Assumes the decode block samples bus lines on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module sbd_host_model (
  input  wire logic  clk_i,
  output logic [2:0] kind_o,
  output logic [19:0] addr_o
);
  initial {kind_o, addr_o} = '0;
  task automatic cyc(input logic [19:0] a, input logic [2:0] k);
    @(posedge clk_i) #1;
    {kind_o, addr_o} = {k, a};
    @(posedge clk_i) #1;
    // Released lines show no stale value
    {kind_o, addr_o} = {3'h0, ~a};
  endtask
endmodule
`default_nettype wire

// [test/support_board_bus_decode_tb.sv]
// Self-checking bench for the support board decode block.
// Assumes outputs register one edge after the bus cycle, switches 3.
`timescale 1ns/10ps
`default_nettype none
module support_board_bus_decode_tb;
  logic clk = 0, rst = 1, dis = 0, cyc_d = 0;
  logic [2:0] k;
  logic [19:0] ad, a;
  logic [26:0] r = 0;
  logic [16:0] q[$], e;
  logic [3:0] b, fs;
  logic bs, rs, ph, wt, oe, tx, po, a3, ad_o;
  logic [7:0] rdd;
  int failures = 0, n_compared = 0, cnt = 0;
  always #25 clk = ~clk;
  sbd_host_model u_host (.clk_i(clk), .kind_o(k), .addr_o(ad));
  sbd_bus_decode u_sbd_bus_decode (.ref_clk_i(clk), .reset_i(rst), .addr_i(ad),
    .mem_cycle_i(k[2]), .io_rd_i(k[1]), .io_wr_i(k[0]), .high_speed_i(r[16]),
    .port_block_a_select_switch_i(r[7:0]), .option_switch_bank_i(r[15:8]), .dtr_i(r[17]),
    .dtr_open_i(r[18]), .dtr_jumper_plus_i(r[19]), .out_jumper_plus_i(r[20]),
    .ack_i(r[21]), .addr_jumper_hi_i(r[22]), .rom_large_i(r[23]),
    .phantom_jumper_i(r[24]), .ack_jumper_three_i(r[25]), .ack_jumper_open_i(r[26]),
    .board_sel_o(bs), .func_sel_o(fs), .rom_sel_o(rs), .phantom_o(ph), .wait_o(wt),
    .rd_data_o(rdd), .rd_data_oe_o(oe), .tx_enable_o(tx), .par_out_oe_o(po),
    .ack_three_byte_o(a3), .ack_drive_bus_o(ad_o));
  task automatic chk(input logic [16:0] g, input logic [16:0] x);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic op(input logic [19:0] x, input logic [2:0] kk);
    logic hit, rom, so;
    hit = (kk[1] | kk[0]) && x[7:4] == b;
    rom = kk[2] && r[4] && !dis && (r[5] ? x[19:12] == 8'hFF : x[15:12] == 4'hF)
      && (r[23] || x[11] == r[22]);
    so = hit && kk[1] && x[3:0] == 4'hF;
    q.push_back({x[3:0], hit, rom, rom & r[24], r[7] & (!r[6] | r[16]), so,
      so ? r[15:8] : 8'h00});
    u_host.cyc(x, kk);
    if (hit && x[3:0] == 4'hE) dis = 1;
  endtask
  always @(posedge clk) begin
    cyc_d <= |k;
    cnt++;
    if (cnt == 5000) begin
      failures++;
      close_out;
    end
  end
  always @(negedge clk) if (cyc_d && q.size() > 0) begin
    e = q.pop_front();
    chk({fs, bs, rs, ph, wt, oe, rdd}, e);
  end
  initial begin
    void'($urandom(18590));
    for (int p = 0; p < 2; p++) begin
      rst = 1;
      dis = 0;
      repeat (10) @(posedge clk);
      #1 rst = 0;
      for (int i = 0; i < 60; i++) begin
        r = $urandom;
        b = {r[0], r[1], r[2], r[3]};
        repeat (4) @(posedge clk);
        chk({tx, po, a3, ad_o}, {r[18] ? r[19] : r[17], r[20] | r[21],
          r[25] & !r[26], !r[26]});
        a = $urandom;
        if (i == 30) op({12'h0, b, 4'hE}, 3'b001);
        op({a[19:8], a[10] ? b : a[7:4], a[9] ? 4'hF : a[3:0]}, a[8] ? 3'b001 : 3'b010);
        if (a[14]) a[19:12] = a[13] ? 8'hFF : {a[19:16], 4'hF};
        op(a, 3'b100);
      end
    end
    repeat (2) @(posedge clk);
    close_out;
  end
endmodule
`default_nettype wire
